// File: lmc_matrix_ctrl.sv
// Operation
// - Dot uses plain PWM when mode is 00 or breathing is disabled.
// - PWM brightness follows register value in 256 linear steps.
// - Breath enable bit turns breathing on, clearing turns it off everywhere.
// - Modes 01, 10, 11 pick breath profile one, two, three.
// - Four phases; rise/fall 0.21s to 26.88s, hold/off 0s to 26.88s.
// - Loop starts at any phase, stops after hold-on or after off.
// - Loop repeats one to 4095 times or endlessly.
// - Profile settings stay pending until the commit register is written.
// - Detect bit rising starts capture; results valid 3264us later.
// - Dots switched off keep their old open/short results.
// - One detection per trigger; clear and set again for the next.
// - Mask selects open, short or profile-done onto interrupt output.
// - Masked event sets status bit and pulls interrupt low together.
// - Interrupt releases on status read or after 8ms with auto clear.
// - Status bits clear when the interrupt is released.
// - Sync role 01 drives clock, 10 follows pin, else pin floats.
// - De-ghost pulls act only while their output is off.
// - Soft shutdown blanks matrix; registers stay accessible and kept.
// - Shutdown pin low blanks matrix; registers stay accessible.
// - Reading the reset register restores all register defaults.
// - Loop count is high field times 256 plus low; zero is endless.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "lmc_defines.svh"
module lmc_matrix_ctrl
	import lmc_pkg::*;
#(
	parameter int DOTS = 48,
	parameter int ROWS = 6,
	parameter int COLS = 8,
	parameter int STEP_CYC = int'(`LMC_STEP_CYC),
	parameter int DETECT_CYC = `LMC_DETECT_CYC,
	parameter int IRQ_HOLD_CYC = `LMC_IRQ_HOLD_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shutdown_pin_n,
	input wire logic [47:0] led_open_in,
	input wire logic [47:0] led_short_in,
	input wire logic sync_i,
	output logic sync_o,
	output logic sync_oe,
	input wire logic irq_out_n_i,
	output logic irq_out_n_o,
	output logic irq_out_n_oe,
	output logic [47:0] dot_drive,
	output logic [7:0] current_level,
	output logic [5:0] row_pullup_en,
	output logic [7:0] col_pulldown_en,
	output logic [2:0] row_pull_code,
	output logic [2:0] col_pull_code
);
	lmc_byte_t pwm_val [DOTS];
	logic [1:0] dot_mode [DOTS];
	logic [47:0] dot_en, open_res, short_res, open_q1, open_q2, short_q1, short_q2;
	lmc_byte_t func_cfg, global_current_level, row_pullup_select, column_pulldown_select;
	lmc_byte_t interrupt_mask, interrupt_status;
	logic [95:0] pend, act;
	logic [8:0] pwm_cnt;
	logic [31:0] step_cnt, det_cnt, hold_cnt;
	logic sd_q1, sd_q2, sync_q1, sync_q2, sync_q3, irq_low;
	lmc_byte_t rd_val;
	lmc_byte_t prof_lvl [3];
	logic [2:0] prof_done;

	// APB decode
	wire [1:0] page = paddr[11:10];
	wire [7:0] idx = paddr[9:2];
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire [7:0] wdat = pwdata[7:0];
	wire pg_dot = page == `LMC_PG_DOT;
	wire pg_func = page == `LMC_PG_FUNC;
	wire dot_idx = idx <= `LMC_IDX_DOT_END;
	wire onoff_hit = pg_dot && idx <= `LMC_IDX_ONOFF_END;
	wire open_hit = pg_dot && idx >= `LMC_IDX_OPEN && idx <= `LMC_IDX_OPEN_END;
	wire short_hit = pg_dot && idx >= `LMC_IDX_SHORT && idx <= `LMC_IDX_SHORT_END;
	wire pwm_hit = page == `LMC_PG_PWM && dot_idx;
	wire mode_hit = page == `LMC_PG_MODE && dot_idx;
	wire prof_hit = pg_func && idx >= `LMC_IDX_PROF && idx <= `LMC_IDX_PROF_END;
	wire func_hit = pg_func && (idx <= `LMC_IDX_RESET || idx == `LMC_IDX_MASK ||
		idx == `LMC_IDX_STATUS);
	wire mapped = onoff_hit || open_hit || short_hit || pwm_hit || mode_hit || func_hit;
	wire [6:0] prof_sel = 7'(idx - `LMC_IDX_PROF);
	wire [5:0] dot_sel = idx[5:0];
	wire [2:0] row_sel = idx[2:0];
	wire [2:0] res_sel = 3'(idx[2:0] - 3'h0);
	wire reg_wipe = reset || (rd && pg_func && idx == `LMC_IDX_RESET);
	wire cfg_wr = wr && pg_func && idx == `LMC_IDX_CFG;
	wire commit = wr && pg_func && idx == `LMC_IDX_COMMIT && wdat == `LMC_COMMIT_VAL;
	wire status_rd = rd && pg_func && idx == `LMC_IDX_STATUS;

	// Operating controls
	wire ben = func_cfg[`LMC_CFG_BEN];
	wire ben_rise = cfg_wr && wdat[`LMC_CFG_BEN] && !ben;
	wire det_start = cfg_wr && wdat[`LMC_CFG_OSD] && !func_cfg[`LMC_CFG_OSD];
	wire det_cap = det_cnt == 32'h0000_0001;
	wire blank = !func_cfg[`LMC_CFG_SSD] || !sd_q2;
	wire [1:0] sync_role = func_cfg[`LMC_CFG_SYNC];
	wire slave = sync_role == `LMC_SYNC_SLAVE;
	wire step = step_cnt == 32'(STEP_CYC - 1);
	wire open_evt = det_cap && |(open_q2 & dot_en);
	wire short_evt = det_cap && |(short_q2 & dot_en);
	wire [4:0] sets = {prof_done, short_evt, open_evt} & interrupt_mask[4:0];
	wire auto_rel = interrupt_mask[`LMC_MASK_IAC] && hold_cnt == 32'(IRQ_HOLD_CYC - 1);
	wire irq_rel = irq_low && (status_rd || auto_rel);

	// Read selection, unused bits read zero
	always_comb begin
		rd_val = `LMC_REG_RST;
		if (onoff_hit) begin
			rd_val = dot_en[{row_sel, 3'h0} +: 8];
		end else if (open_hit) begin
			rd_val = open_res[{res_sel, 3'h0} +: 8];
		end else if (short_hit) begin
			rd_val = short_res[{res_sel, 3'h0} +: 8];
		end else if (pwm_hit) begin
			rd_val = pwm_val[dot_sel];
		end else if (mode_hit) begin
			rd_val = {6'h00, dot_mode[dot_sel]};
		end else if (prof_hit) begin
			rd_val = pend[{prof_sel[3:0], 3'h0} +: 8];
		end else if (pg_func) begin
			case (idx)
				`LMC_IDX_CFG: rd_val = func_cfg;
				`LMC_IDX_GCL: rd_val = global_current_level;
				`LMC_IDX_PULLUP: rd_val = row_pullup_select;
				`LMC_IDX_PULLDOWN: rd_val = column_pulldown_select;
				`LMC_IDX_MASK: rd_val = interrupt_mask;
				`LMC_IDX_STATUS: rd_val = interrupt_status;
				default: rd_val = `LMC_REG_RST;
			endcase
		end
	end

	// APB answer, one wait state
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= {24'h00_0000, rd_val};
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// Per-dot storage, kept through shutdown
	always_ff @(posedge clk) begin
		if (reg_wipe) begin
			for (int i = 0; i < DOTS; i++) begin
				pwm_val[i] <= `LMC_REG_RST;
				dot_mode[i] <= `LMC_MODE_PWM;
			end
			dot_en <= 48'h0000_0000_0000;
		end else if (wr) begin
			if (pwm_hit) begin
				pwm_val[dot_sel] <= wdat;
			end
			if (mode_hit) begin
				dot_mode[dot_sel] <= wdat[1:0];
			end
			if (onoff_hit) begin
				dot_en[{row_sel, 3'h0} +: 8] <= wdat;
			end
		end
	end

	// Function registers with pending profile timing
	always_ff @(posedge clk) begin
		if (reg_wipe) begin
			func_cfg <= `LMC_REG_RST;
			global_current_level <= `LMC_REG_RST;
			row_pullup_select <= `LMC_REG_RST;
			column_pulldown_select <= `LMC_REG_RST;
			interrupt_mask <= `LMC_REG_RST;
			pend <= 96'h0;
			act <= 96'h0;
		end else begin
			if (wr && prof_hit) begin
				pend[{prof_sel[3:0], 3'h0} +: 8] <= wdat;
			end
			if (commit) begin
				act <= pend;
			end
			if (cfg_wr) begin
				func_cfg <= wdat;
			end
			if (wr && pg_func && idx == `LMC_IDX_GCL) begin
				global_current_level <= wdat;
			end
			if (wr && pg_func && idx == `LMC_IDX_PULLUP) begin
				row_pullup_select <= {5'h00, wdat[2:0]};
			end
			if (wr && pg_func && idx == `LMC_IDX_PULLDOWN) begin
				column_pulldown_select <= {5'h00, wdat[2:0]};
			end
			if (wr && pg_func && idx == `LMC_IDX_MASK) begin
				interrupt_mask <= {wdat[7], 2'h0, wdat[4:0]};
			end
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk) begin
		sd_q1 <= shutdown_pin_n;
		sd_q2 <= sd_q1;
		sync_q1 <= sync_i;
		sync_q2 <= sync_q1;
		sync_q3 <= sync_q2;
		open_q1 <= led_open_in;
		open_q2 <= open_q1;
		short_q1 <= led_short_in;
		short_q2 <= short_q1;
	end

	// Scan counter, step timer, sync master clock
	always_ff @(posedge clk) begin
		if (reset || (slave && sync_q2 && !sync_q3)) begin
			pwm_cnt <= 9'h000;
		end else begin
			pwm_cnt <= pwm_cnt + 9'h001;
		end
		step_cnt <= (reset || step) ? 32'h0000_0000 : step_cnt + 32'h0000_0001;
		sync_oe <= !reset && (sync_role == `LMC_SYNC_MASTER);
		sync_o <= !reset && pwm_cnt[8];
	end

	// One-shot open/short capture
	always_ff @(posedge clk) begin
		if (reg_wipe) begin
			det_cnt <= 32'h0000_0000;
			open_res <= 48'h0000_0000_0000;
			short_res <= 48'h0000_0000_0000;
		end else begin
			if (det_start) begin
				det_cnt <= 32'(DETECT_CYC);
			end else if (det_cnt != 32'h0000_0000) begin
				det_cnt <= det_cnt - 32'h0000_0001;
			end
			if (det_cap) begin
				open_res <= (open_q2 & dot_en) | (open_res & ~dot_en);
				short_res <= (short_q2 & dot_en) | (short_res & ~dot_en);
			end
		end
	end

	// Interrupt status, set wins over release
	always_ff @(posedge clk) begin
		if (reg_wipe) begin
			interrupt_status <= `LMC_REG_RST;
			irq_low <= 1'b0;
			hold_cnt <= 32'h0000_0000;
		end else begin
			interrupt_status <= {3'h0, (irq_rel ? 5'h00 : interrupt_status[4:0]) | sets};
			irq_low <= (irq_low && !irq_rel) || |sets;
			hold_cnt <= (irq_low && !irq_rel) ? hold_cnt + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// Open-drain interrupt pin
	always_ff @(posedge clk) begin
		irq_out_n_oe <= !reset && ((irq_low && !irq_rel) || |sets);
		irq_out_n_o <= 1'b0;
	end

	// Breath engines, restarted on commit or enable
	for (genvar p = 0; p < 3; p++) begin : g_prof
		lmc_breath_engine u_eng (
			.clk(clk),
			.reset(reset),
			.run(ben),
			.restart(commit || ben_rise),
			.step(step),
			.prof(act[32*p +: 32]),
			.level(prof_lvl[p]),
			.done(prof_done[p])
		);
	end

	// Dot brightness and drive
	for (genvar d = 0; d < DOTS; d++) begin : g_dot
		wire use_pwm = dot_mode[d] == `LMC_MODE_PWM || !ben;
		wire [7:0] lvl = use_pwm ? pwm_val[d] : prof_lvl[2'(dot_mode[d] - 2'h1)];
		always_ff @(posedge clk) begin
			dot_drive[d] <= !reset && !blank && dot_en[d] && ({1'b0, lvl} > pwm_cnt);
		end
	end

	// De-ghost pull enables while outputs are off
	for (genvar r = 0; r < ROWS; r++) begin : g_row
		always_ff @(posedge clk) begin
			row_pullup_en[r] <= !reset && row_pullup_select[2:0] != 3'h0 &&
				!(|dot_drive[COLS*r +: COLS]);
		end
	end
	for (genvar c = 0; c < COLS; c++) begin : g_col
		wire col_on = dot_drive[c] | dot_drive[c+8] | dot_drive[c+16] |
			dot_drive[c+24] | dot_drive[c+32] | dot_drive[c+40];
		always_ff @(posedge clk) begin
			col_pulldown_en[c] <= !reset && column_pulldown_select[2:0] != 3'h0 && !col_on;
		end
	end

	// Current level and pull codes out
	always_ff @(posedge clk) begin
		current_level <= (reset || blank) ? 8'h00 : global_current_level;
		row_pull_code <= row_pullup_select[2:0];
		col_pull_code <= column_pulldown_select[2:0];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_IRQ_WITH_STATUS: assert property (open_evt && interrupt_mask[0] |=>
		interrupt_status[0] && irq_out_n_oe) else $error("open event did not pull irq low");
	AST_READ_RELEASE: assert property (status_rd && irq_low && sets == 5'h00 |=>
		!irq_out_n_oe && interrupt_status == 8'h00) else $error("status read kept irq low");
	AST_AUTO_BOUND: assert property (irq_low && interrupt_mask[7] |->
		hold_cnt < 32'(IRQ_HOLD_CYC)) else $error("auto release overdue");
	AST_STATUS_CLEAR: assert property (!irq_low |-> interrupt_status == 8'h00)
		else $error("status set while irq released");
	AST_BLANK: assert property (blank |=> dot_drive == 48'h0 && current_level == 8'h00)
		else $error("dots driven in shutdown");
	AST_PENDING: assert property (!commit && !reg_wipe |=> $stable(act))
		else $error("active timing changed without commit");
	AST_SYNC_OFF: assert property (sync_role != `LMC_SYNC_MASTER |=> !sync_oe)
		else $error("sync pin driven outside master role");
	AST_PWM_STEP: assert property (!blank && dot_en[0] && dot_mode[0] == 2'h0 &&
		{1'b0, pwm_val[0]} > pwm_cnt |=> dot_drive[0]) else $error("pwm dot not lit");
	AST_KEEP_OFF: assert property (det_cap |=>
		((open_res ^ $past(open_res)) & ~$past(dot_en)) == 48'h0) else $error("off dot refreshed");
	AST_PULL_OFF: assert property (dot_drive[0] |=>
		!row_pullup_en[0] && !col_pulldown_en[0]) else $error("pull active on driven line");
	COV_COMMIT: cover property (commit ##1 ben);
	COV_DETECT: cover property (det_cap && open_evt);
	COV_READ_REL: cover property (irq_low ##1 status_rd);
	COV_DONE: cover property (|prof_done);
endmodule // lmc_matrix_ctrl

// File: lmc_defines.svh
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

// Register pages, taken from paddr[11:10]
`define LMC_PG_DOT 2'h0
`define LMC_PG_PWM 2'h1
`define LMC_PG_MODE 2'h2
`define LMC_PG_FUNC 2'h3

// Register indices, byte address is four times the index
`define LMC_IDX_ONOFF_END 8'h05
`define LMC_IDX_OPEN 8'h18
`define LMC_IDX_OPEN_END 8'h1D
`define LMC_IDX_SHORT 8'h30
`define LMC_IDX_SHORT_END 8'h35
`define LMC_IDX_DOT_END 8'h2F
`define LMC_IDX_CFG 8'h00
`define LMC_IDX_GCL 8'h01
`define LMC_IDX_PROF 8'h02
`define LMC_IDX_PROF_END 8'h0D
`define LMC_IDX_COMMIT 8'h0E
`define LMC_IDX_PULLUP 8'h0F
`define LMC_IDX_PULLDOWN 8'h10
`define LMC_IDX_RESET 8'h11
`define LMC_IDX_MASK 8'hF0
`define LMC_IDX_STATUS 8'hF1

// Field positions and values
`define LMC_CFG_SSD 0
`define LMC_CFG_BEN 1
`define LMC_CFG_OSD 2
`define LMC_CFG_SYNC 7:6
`define LMC_MASK_IAC 7
`define LMC_SYNC_MASTER 2'h1
`define LMC_SYNC_SLAVE 2'h2
`define LMC_COMMIT_VAL 8'h00
`define LMC_REG_RST 8'h00
`define LMC_MODE_PWM 2'h0

// Timing
`define LMC_CLK_MHZ 250
`define LMC_PHASE_UNIT_NS 64'd210000000
`define LMC_STEP_CYC (`LMC_PHASE_UNIT_NS * `LMC_CLK_MHZ / 1000 / 256)
`define LMC_DETECT_US 3264
`define LMC_DETECT_CYC (`LMC_DETECT_US * `LMC_CLK_MHZ)
`define LMC_IRQ_HOLD_US 8000
`define LMC_IRQ_HOLD_CYC (`LMC_IRQ_HOLD_US * `LMC_CLK_MHZ)

`endif

// File: lmc_pkg.sv
package lmc_pkg;
	typedef enum logic [1:0] {PH_RISE, PH_HOLD, PH_FALL, PH_OFF} lmc_phase_t;
	typedef logic [7:0] lmc_byte_t;
endpackage

// File: lmc_breath_engine.sv
`timescale 1ns/10ps
`include "lmc_defines.svh"
module lmc_breath_engine
	import lmc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic restart,
	input wire logic step,
	input wire logic [31:0] prof,
	output lmc_byte_t level,
	output logic done
);
	lmc_phase_t phase;
	logic [14:0] elapsed;
	logic [11:0] loops;
	logic stopped;

	// Profile fields
	wire [2:0] rise_code = prof[2:0];
	wire [3:0] hold_code = prof[7:4];
	wire [2:0] fall_code = prof[10:8];
	wire [3:0] off_code = prof[15:12];
	wire [1:0] loop_begin = prof[17:16];
	wire loop_end_lit = prof[18];
	wire [11:0] loop_count = {prof[23:20], prof[31:24]};

	// Phase length as a power of two of the base unit
	wire [3:0] wait_code = (phase == PH_HOLD) ? hold_code : off_code;
	wire [3:0] wait_cap = (wait_code > 4'h8) ? 4'h8 : wait_code;
	wire zero_len = (phase == PH_HOLD || phase == PH_OFF) && wait_code == 4'h0;
	wire [2:0] shift = (phase == PH_RISE) ? rise_code :
		(phase == PH_FALL) ? fall_code : 3'(wait_cap - 4'h1);
	wire [15:0] span = (16'h0100 << shift) - 16'h0001;
	wire phase_last = zero_len || {1'b0, elapsed} == span;
	wire at_end = loop_end_lit ? (phase == PH_HOLD) : (phase == PH_OFF);
	wire [11:0] next_loops = loops + 12'h001;
	wire finish = loop_count != 12'h000 && next_loops == loop_count;
	wire [14:0] ramp = elapsed >> shift;

	// Brightness per phase
	assign level = (phase == PH_RISE) ? ramp[7:0] :
		(phase == PH_HOLD) ? 8'hFF :
		(phase == PH_FALL) ? 8'hFF - ramp[7:0] : 8'h00;

	// Phase sequencer
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (reset || restart || !run) begin
			phase <= lmc_phase_t'(loop_begin);
			elapsed <= 15'h0000;
			loops <= 12'h000;
			stopped <= 1'b0;
		end else if (step && !stopped) begin
			if (!phase_last) begin
				elapsed <= elapsed + 15'h0001;
			end else begin
				elapsed <= 15'h0000;
				if (at_end && finish) begin
					stopped <= 1'b1;
					done <= 1'b1;
				end else begin
					phase <= lmc_phase_t'(phase + 2'h1);
					if (at_end) begin
						loops <= next_loops;
					end
				end
			end
		end
	end
endmodule // lmc_breath_engine

// File: lmc_board_model.sv
`timescale 1ns/10ps
module lmc_board_model (
	input wire logic clk,
	input wire logic irq_oe,
	input wire logic sync_o,
	input wire logic sync_oe,
	input wire logic [47:0] open_f,
	input wire logic [47:0] short_f,
	output logic irq_pin,
	output logic sync_pin,
	output logic [47:0] led_open_in,
	output logic [47:0] led_short_in
);
	logic idle_tgl = 1'b0;
	// Floating sync line wanders each cycle
	always_ff @(posedge clk) begin
		idle_tgl <= ~idle_tgl;
	end
	// Pull-up on the open-drain line
	assign irq_pin = irq_oe ? 1'b0 : 1'b1;
	assign sync_pin = sync_oe ? sync_o : idle_tgl;
	// Comparators flag faulted dots
	assign led_open_in = open_f;
	assign led_short_in = short_f;
endmodule // lmc_board_model

// File: led_matrix_mode_control_tb.sv
`timescale 1ns/10ps
`include "lmc_defines.svh"
module led_matrix_mode_control_tb;
	localparam logic [1:0] PD = `LMC_PG_DOT;
	localparam logic [1:0] PW = `LMC_PG_PWM;
	localparam logic [1:0] PM = `LMC_PG_MODE;
	localparam logic [1:0] PF = `LMC_PG_FUNC;
	localparam int HOLD = 30;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, shutdown_pin_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [47:0] open_f, short_f, lio, lis, dot_drive;
	logic sync_pin, sync_o, sync_oe, irq_pin, irq_o, irq_oe, errv;
	logic [7:0] current_level, col_pulldown_en;
	logic [5:0] row_pullup_en;
	logic [2:0] row_pull_code, col_pull_code;
	int failures = 0;
	int n_compared = 0;
	int nw;
	lmc_matrix_ctrl #(.STEP_CYC(2), .DETECT_CYC(20), .IRQ_HOLD_CYC(HOLD)) dut_u (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shutdown_pin_n(shutdown_pin_n), .led_open_in(lio),
		.led_short_in(lis), .sync_i(sync_pin), .sync_o(sync_o), .sync_oe(sync_oe),
		.irq_out_n_i(irq_pin), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe),
		.dot_drive(dot_drive), .current_level(current_level),
		.row_pullup_en(row_pullup_en), .col_pulldown_en(col_pulldown_en),
		.row_pull_code(row_pull_code), .col_pull_code(col_pull_code)
	);
	lmc_board_model board_u (
		.clk(clk), .irq_oe(irq_oe), .sync_o(sync_o), .sync_oe(sync_oe),
		.open_f(open_f), .short_f(short_f), .irq_pin(irq_pin), .sync_pin(sync_pin),
		.led_open_in(lio), .led_short_in(lis)
	);
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Verdict and end of run
	task close_out;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task timeout(input string nm);
		failures++;
		$display("unexpected %s expected event seen timeout", nm);
		close_out;
	endtask
	// One APB transfer, held until pready
	task apb(input logic w, input logic [1:0] pg, input logic [7:0] ix, input logic [7:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {pg, ix, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) timeout("pready");
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [1:0] pg, input logic [7:0] ix, input logic [7:0] d);
		apb(1'b1, pg, ix, d);
	endtask
	task rc(input string nm, input logic [1:0] pg, input logic [7:0] ix, input logic [31:0] e);
		apb(1'b0, pg, ix, 8'h00);
		chk(nm, rdv, e);
	endtask
	task wirq(input logic lv, input int lim);
		nw = 0;
		while (irq_pin !== lv) begin
			if (nw >= lim) timeout("irq");
			@(posedge clk);
			nw++;
		end
	endtask
	task wsync(input logic lv);
		int n;
		n = 0;
		while (sync_o !== lv) begin
			if (n >= 2000) timeout("sync");
			@(posedge clk);
			n++;
		end
	endtask
	// Lit share of dot 0 over one sync period
	task duty(input string nm);
		int p, h;
		logic s0;
		wsync(1'b0);
		wsync(1'b1);
		p = 0;
		h = 0;
		s0 = 1'b0;
		do begin
			h += int'(dot_drive[0] === 1'b1);
			@(posedge clk);
			p++;
			if (sync_o === 1'b0) s0 = 1'b1;
		end while (!(s0 && sync_o === 1'b1) && p < 5000);
		chk(nm, 48'(h * 128), 48'(p));
	endtask
	task dark(input string nm);
		logic [47:0] acc;
		acc = 48'h0;
		repeat (4) @(posedge clk);
		repeat (600) begin
			@(posedge clk);
			acc |= dot_drive | 48'(current_level);
		end
		chk(nm, acc, 48'h0);
	endtask
	task t_regs;
		rc("cfg_default", PF, `LMC_IDX_CFG, 32'h0);
		chk("sync_oe_default", sync_oe, 1'b0);
		wr(PF, `LMC_IDX_GCL, 8'h5A);
		rc("gcl", PF, `LMC_IDX_GCL, 32'h5A);
		apb(1'b0, PD, 8'h08, 8'h00);
		chk("unmapped_err", errv, 1'b1);
		chk("unmapped_data", rdv, 48'h0);
	endtask
	task t_pwm;
		for (int r = 0; r < 6; r++) wr(PD, 8'(r), 8'hFF);
		wr(PW, 8'h00, 8'h04);
		wr(PF, `LMC_IDX_GCL, 8'h80);
		wr(PF, `LMC_IDX_CFG, 8'h41);
		duty("pwm_duty");
		chk("level", current_level, 48'h80);
		wr(PF, `LMC_IDX_CFG, 8'h43);
		duty("mode0_breath_on");
		wr(PM, 8'h00, 8'h01);
		wr(PF, `LMC_IDX_CFG, 8'h41);
		duty("mode1_breath_off");
	endtask
	task t_shut;
		wr(PF, `LMC_IDX_CFG, 8'h40);
		dark("soft_dark");
		rc("gcl_soft", PF, `LMC_IDX_GCL, 32'h80);
		wr(PF, `LMC_IDX_CFG, 8'h41);
		shutdown_pin_n <= 1'b0;
		dark("hard_dark");
		wr(PF, `LMC_IDX_GCL, 8'h33);
		rc("gcl_hard", PF, `LMC_IDX_GCL, 32'h33);
		shutdown_pin_n <= 1'b1;
	endtask
	task t_sync;
		for (int r = 0; r < 4; r++) begin
			wr(PF, `LMC_IDX_CFG, {2'(r), 6'h01});
			@(posedge clk);
			chk("sync_oe", sync_oe, r == 1);
		end
	endtask
	task t_pull;
		wr(PF, `LMC_IDX_CFG, 8'h00);
		wr(PF, `LMC_IDX_PULLUP, 8'hFF);
		rc("pu_read", PF, `LMC_IDX_PULLUP, 32'h7);
		wr(PF, `LMC_IDX_PULLDOWN, 8'h05);
		repeat (3) @(posedge clk);
		chk("pu_code", row_pull_code, 3'h7);
		chk("pd_code", col_pull_code, 3'h5);
		chk("pu_en", row_pullup_en, 6'h3F);
		chk("pd_en", col_pulldown_en, 8'hFF);
		wr(PF, `LMC_IDX_PULLUP, 8'h00);
		repeat (3) @(posedge clk);
		chk("pu_off", row_pullup_en, 6'h00);
	endtask
	task t_breath;
		logic [7:0] ctl [3];
		ctl = '{8'h00, 8'h04, 8'h07};
		for (int p = 0; p < 3; p++) begin
			wr(PM, 8'h00, 8'(p + 1));
			wr(PF, `LMC_IDX_MASK, 8'(4 << p));
			wr(PF, 8'(2 + 4 * p), 8'h00);
			wr(PF, 8'(3 + 4 * p), 8'h00);
			wr(PF, 8'(4 + 4 * p), ctl[p]);
			wr(PF, 8'(5 + 4 * p), 8'h01);
			if (p == 0) begin
				wr(PF, `LMC_IDX_CFG, 8'h43);
				repeat (3000) @(posedge clk);
				chk("pending", irq_pin, 1'b1);
				rc("pending_read", PF, 8'h05, 32'h1);
			end
			wr(PF, `LMC_IDX_COMMIT, `LMC_COMMIT_VAL);
			wirq(1'b0, 4000);
			rc("done", PF, `LMC_IDX_STATUS, 32'(4 << p));
			chk("irq_released", irq_pin, 1'b1);
			rc("status_clear", PF, `LMC_IDX_STATUS, 32'h0);
		end
		wr(PF, `LMC_IDX_CFG, 8'h41);
	endtask
	task t_detect;
		wr(PD, 8'h00, 8'hFE);
		wr(PF, `LMC_IDX_GCL, 8'h01);
		open_f <= 48'h3;
		short_f <= 48'h200;
		wr(PF, `LMC_IDX_MASK, 8'h03);
		wr(PF, `LMC_IDX_CFG, 8'h45);
		wirq(1'b0, 100);
		chk("irq_drive", irq_o, 1'b0);
		rc("fault_status", PF, `LMC_IDX_STATUS, 32'h3);
		rc("open_row0", PD, `LMC_IDX_OPEN, 32'h2);
		rc("short_row1", PD, 8'h31, 32'h2);
		open_f <= 48'h7;
		rc("one_shot", PD, `LMC_IDX_OPEN, 32'h2);
		wr(PF, `LMC_IDX_MASK, 8'h81);
		wr(PF, `LMC_IDX_CFG, 8'h41);
		wr(PF, `LMC_IDX_CFG, 8'h45);
		wirq(1'b0, 100);
		wirq(1'b1, 100);
		chk("auto_clear", nw >= HOLD - 2 && nw <= HOLD + 2, 1'b1);
		rc("auto_status", PF, `LMC_IDX_STATUS, 32'h0);
		rc("retrigger", PD, `LMC_IDX_OPEN, 32'h6);
	endtask
	task t_reset;
		apb(1'b0, PF, `LMC_IDX_RESET, 8'h00);
		rc("gcl_reset", PF, `LMC_IDX_GCL, 32'h0);
		rc("mask_reset", PF, `LMC_IDX_MASK, 32'h0);
	endtask
	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		shutdown_pin_n = 1'b1;
		open_f = 48'h0;
		short_f = 48'h0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_regs;
		t_pwm;
		t_shut;
		t_sync;
		t_pull;
		t_breath;
		t_detect;
		t_reset;
		close_out;
	end
endmodule // led_matrix_mode_control_tb
